// file: mpul_pkg.sv
// Package for the multiprocessor serial link: offsets, fields, resets.
// Assumes a 32-bit classic Wishbone slave and a 16x bit-rate tick.
package mpul_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_TXD  = 8'h08;
    localparam logic [7:0] ADDR_RXD  = 8'h0c;
    localparam logic [7:0] ADDR_BAUD = 8'h10;
    // Control field positions
    localparam int C_TE    = 0;
    localparam int C_RE    = 1;
    localparam int C_TIE   = 2;
    localparam int C_RIE   = 3;
    localparam int C_TX_END_IRQ_ENABLE  = 4;
    localparam int C_ADDR_WAIT_IRQ_ENABLE  = 5;
    localparam int C_CHR8  = 6;
    localparam int C_STOP2 = 7;
    localparam int C_PAREN = 8;
    localparam int C_PDIR  = 9;
    localparam int C_PLVL  = 10;
    localparam int CTRL_W  = 11;
    localparam logic [10:0] CTRL_RST = 11'h040;
    // Status field positions
    localparam int S_TX_BUFFER_EMPTY_FLAG  = 0;
    localparam int S_TX_END_FLAG  = 1;
    localparam int S_RX_BUFFER_FULL_FLAG  = 2;
    localparam int S_OVERRUN_FLAG  = 3;
    localparam int S_FER   = 4;
    localparam int S_MPB   = 5;
    localparam int S_OUTGOING_ADDR_FLAG_BIT  = 6;
    localparam int S_RXPIN = 7;
    // Baud divisor reset: clk cycles per 16x tick, minus one
    localparam logic [15:0] BAUD_RST = 16'h0043;
    // Oversampling: last tick of a bit, and mid-start sample point
    localparam logic [3:0] TK_LAST = 4'hf;
    localparam logic [3:0] TK_MID  = 4'h7;
    typedef enum logic [2:0] {
        MPUL_IDLE  = 3'b000,
        MPUL_START = 3'b001,
        MPUL_DATA  = 3'b010,
        MPUL_MPB   = 3'b011,
        MPUL_STOP  = 3'b100
    } mpul_st_t;
endpackage

// file: mpul_tick_if.sv
// Interface carrying the baud divisor out and the 16x tick back.
// Assumes both ends sit on clk_sys.
`timescale 1ns/100ps
interface mpul_tick_if;
    logic [15:0] div;
    logic        tick;
    modport gen (input div, output tick);
    modport use_ (output div, input tick);
endinterface

// file: mpul_baud.sv
// Divider making the one-cycle 16x bit-rate enable.
// Assumes clk_sys domain and a divisor held by the register file.
`timescale 1ns/100ps
module mpul_baud (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Tick carrier
    mpul_tick_if.gen  tk
);
    import mpul_pkg::*;

    logic [15:0] cnt_q;
    logic        tick_q;
    wire         wrap = (cnt_q >= tk.div);

    // Count up to the divisor, pulse once per wrap
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cnt_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= wrap ? 16'h0000 : cnt_q + 16'h0001;
            tick_q <= wrap;
        end
    end

    assign tk.tick = tick_q;
endmodule

// file: mpul_link.sv
// Multiprocessor-format async serial channel with Wishbone registers.
// Assumes one clk_sys domain; rxd_i is asynchronous and synchronised.
`timescale 1ns/100ps
module mpul_link (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // Wishbone slave
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Transfer controller
    input  wire logic        xfer_tx_wr,
    input  wire logic [7:0]  xfer_tx_data,
    input  wire logic        xfer_rx_rd,
    output logic [7:0]       xfer_rx_data,
    // Serial pins
    output logic             txd_o,
    output logic             txd_oe_n,
    input  wire logic        rxd_i,
    // Interrupt requests
    output logic             tx_empty_irq,
    output logic             tx_end_irq,
    output logic             rx_full_irq,
    output logic             rx_error_irq
);
    import mpul_pkg::*;

    // Merge written byte lanes into a 16-bit register
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [15:0] nw,
                                               input logic [1:0]  sel);
        lane_merge = {sel[1] ? nw[15:8] : old[15:8],
                      sel[0] ? nw[7:0]  : old[7:0]};
    endfunction

    // Registers
    logic [CTRL_W-1:0] serial_control_reg;
    logic [15:0]       baud_q;
    logic [7:0]        tx_holding_buffer;
    logic [7:0]        rx_holding_buffer;
    logic              tx_buffer_empty_flag;
    logic              tx_end_flag;
    logic              rx_buffer_full_flag;
    logic              overrun_flag;
    logic              framing_flag;
    logic              rx_mpb_q;
    logic              outgoing_addr_flag_bit;
    logic              ack_q;
    logic [31:0]       rdat_q;

    // Baud tick
    mpul_tick_if tk_if ();
    assign tk_if.div = baud_q;
    mpul_baud u_baud (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tk      (tk_if)
    );
    wire tick = tk_if.tick;

    // Control fields
    wire transmit_enable_bit  = serial_control_reg[C_TE];
    wire rx_enable            = serial_control_reg[C_RE];
    wire tx_empty_irq_enable  = serial_control_reg[C_TIE];
    wire rx_irq_enable        = serial_control_reg[C_RIE];
    wire tx_end_irq_enable    = serial_control_reg[C_TX_END_IRQ_ENABLE];
    wire addr_wait_irq_enable = serial_control_reg[C_ADDR_WAIT_IRQ_ENABLE];
    wire chr8                 = serial_control_reg[C_CHR8];
    wire stop2                = serial_control_reg[C_STOP2];
    wire port_dir_bit         = serial_control_reg[C_PDIR];
    wire port_level_bit       = serial_control_reg[C_PLVL];
    // Parity enable is stored but never read by the framing logic
    wire [2:0] last_bit = chr8 ? 3'd7 : 3'd6;

    // Bus decode; write lands on the edge where ack is seen
    wire req    = wb_cyc_i & wb_stb_i;
    wire wr_stb = req & wb_we_i & ack_q;
    wire wr_ctl = wr_stb & (wb_adr_i == ADDR_CTRL);
    wire wr_sts = wr_stb & (wb_adr_i == ADDR_STAT) & wb_sel_i[0];
    wire wr_txd = wr_stb & (wb_adr_i == ADDR_TXD) & wb_sel_i[0];
    wire wr_bd  = wr_stb & (wb_adr_i == ADDR_BAUD);
    wire [15:0] ctl_new = lane_merge({5'h00, serial_control_reg},
                                     wb_dat_i[15:0], wb_sel_i[1:0]);

    // Software clears flags by writing zero to them
    wire clr_tx_buffer_empty_flag = wr_sts & ~wb_dat_i[S_TX_BUFFER_EMPTY_FLAG];
    wire clr_tx_end_flag = wr_sts & ~wb_dat_i[S_TX_END_FLAG];
    wire clr_rx_buffer_full_flag = (wr_sts & ~wb_dat_i[S_RX_BUFFER_FULL_FLAG]) | xfer_rx_rd;
    wire clr_overrun_flag = wr_sts & ~wb_dat_i[S_OVERRUN_FLAG];
    wire clr_fer  = wr_sts & ~wb_dat_i[S_FER];

    // Receive pin synchroniser
    logic rxd_s1_q;
    logic rxd_s2_q;
    always_ff @(posedge clk_sys) begin
        rxd_s1_q <= rxd_i;
        rxd_s2_q <= rxd_s1_q;
    end

    // Transmitter state
    mpul_st_t    tx_st_q;
    logic [3:0]  tx_tk_q;
    logic [2:0]  tx_bit_q;
    logic        tx_stop_n_q;
    logic        tx_pend_q;
    logic [7:0]  tx_shift_reg;
    logic        tx_mpb_q;
    logic        txd_line;

    wire tx_bend = tick & (tx_tk_q == TK_LAST);
    // Empty flag is sampled at the first tick of the first stop bit
    wire tx_chk  = tick & (tx_st_q == MPUL_STOP) & (tx_tk_q == 4'h0)
                   & ~tx_stop_n_q & ~tx_pend_q;
    wire tx_new  = transmit_enable_bit & ~tx_buffer_empty_flag;
    wire tx_ld_i = (tx_st_q == MPUL_IDLE) & tx_new;
    wire tx_ld_s = tx_chk & tx_new;
    wire tx_load = tx_ld_i | tx_ld_s;

    // Line level by phase; mark outside frames
    always_comb begin
        case (tx_st_q)
            MPUL_START: txd_line = 1'b0;
            MPUL_DATA:  txd_line = tx_shift_reg[0];
            MPUL_MPB:   txd_line = tx_mpb_q;
            MPUL_STOP:  txd_line = 1'b1;
            default:    txd_line = 1'b1;
        endcase
    end

    // Frame sequencer; dropping enable aborts at once for a break
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !transmit_enable_bit) begin
            tx_st_q     <= MPUL_IDLE;
            tx_tk_q     <= 4'h0;
            tx_bit_q    <= 3'd0;
            tx_stop_n_q <= 1'b0;
            tx_pend_q   <= 1'b0;
        end else if (tx_ld_i) begin
            tx_st_q <= MPUL_START;
            tx_tk_q <= 4'h0;
        end else begin
            if (tick)
                tx_tk_q <= tx_tk_q + 4'h1;
            if (tx_ld_s)
                tx_pend_q <= 1'b1;
            if (tx_bend) begin
                case (tx_st_q)
                    MPUL_START: begin
                        tx_st_q  <= MPUL_DATA;
                        tx_bit_q <= 3'd0;
                    end
                    MPUL_DATA: begin
                        tx_bit_q <= tx_bit_q + 3'd1;
                        if (tx_bit_q == last_bit)
                            tx_st_q <= MPUL_MPB;
                    end
                    MPUL_MPB: begin
                        tx_st_q     <= MPUL_STOP;
                        tx_stop_n_q <= 1'b0;
                    end
                    MPUL_STOP: begin
                        if (stop2 && !tx_stop_n_q) begin
                            tx_stop_n_q <= 1'b1;
                        end else begin
                            tx_st_q   <= tx_pend_q ? MPUL_START : MPUL_IDLE;
                            tx_pend_q <= 1'b0;
                        end
                    end
                    default: tx_st_q <= MPUL_IDLE;
                endcase
            end
        end
    end

    // Shift register: load from holding buffer, shift LSB first
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_shift_reg <= 8'h00;
            tx_mpb_q     <= 1'b0;
        end else if (tx_load) begin
            tx_shift_reg <= tx_holding_buffer;
            tx_mpb_q     <= outgoing_addr_flag_bit;
        end else if (tx_bend && tx_st_q == MPUL_DATA) begin
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
        end
    end

    // Empty and end flags; hardware set wins over any clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !transmit_enable_bit) begin
            tx_buffer_empty_flag <= 1'b1;
            tx_end_flag          <= 1'b1;
        end else begin
            if (tx_load)
                tx_buffer_empty_flag <= 1'b1;
            else if (clr_tx_buffer_empty_flag || xfer_tx_wr)
                tx_buffer_empty_flag <= 1'b0;
            if (tx_chk && tx_buffer_empty_flag)
                tx_end_flag <= 1'b1;
            else if (tx_load || clr_tx_end_flag)
                tx_end_flag <= 1'b0;
        end
    end

    // Holding buffer and outgoing address bit
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_holding_buffer      <= 8'h00;
            outgoing_addr_flag_bit <= 1'b0;
        end else begin
            if (xfer_tx_wr)
                tx_holding_buffer <= xfer_tx_data;
            else if (wr_txd)
                tx_holding_buffer <= wb_dat_i[7:0];
            if (wr_sts)
                outgoing_addr_flag_bit <= wb_dat_i[S_OUTGOING_ADDR_FLAG_BIT];
        end
    end

    // Pin: serial function when enabled, else port bits
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txd_o    <= 1'b1;
            txd_oe_n <= 1'b1;
        end else begin
            txd_o    <= transmit_enable_bit ? txd_line : port_level_bit;
            txd_oe_n <= ~(transmit_enable_bit | port_dir_bit);
        end
    end

    // Receiver state
    mpul_st_t    rx_st_q;
    logic [3:0]  rx_tk_q;
    logic [2:0]  rx_bit_q;
    logic [7:0]  rx_shift_reg;
    logic        rx_mpb_in_q;

    wire rx_err  = overrun_flag | framing_flag;
    wire rx_smp  = tick & (rx_tk_q == TK_LAST);
    wire rx_done = rx_smp & (rx_st_q == MPUL_STOP);
    // Only the first stop bit is looked at
    wire rx_stop = rxd_s2_q;
    wire rx_skip = addr_wait_irq_enable & ~rx_mpb_in_q;
    wire rx_acc  = rx_done & ~rx_skip;
    wire rx_ovr  = rx_acc & rx_buffer_full_flag;
    wire rx_load = rx_acc & ~rx_buffer_full_flag;
    wire [7:0] rx_char = chr8 ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]};

    // Receive sequencer; held idle while an error flag stands
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !rx_enable) begin
            rx_st_q  <= MPUL_IDLE;
            rx_tk_q  <= 4'h0;
            rx_bit_q <= 3'd0;
        end else if (tick) begin
            rx_tk_q <= rx_tk_q + 4'h1;
            case (rx_st_q)
                MPUL_IDLE: begin
                    rx_tk_q <= 4'h0;
                    if (!rxd_s2_q && !rx_err)
                        rx_st_q <= MPUL_START;
                end
                MPUL_START: begin
                    if (rx_tk_q == TK_MID) begin
                        rx_tk_q  <= 4'h0;
                        rx_bit_q <= 3'd0;
                        rx_st_q  <= rxd_s2_q ? MPUL_IDLE : MPUL_DATA;
                    end
                end
                MPUL_DATA: begin
                    if (rx_smp) begin
                        rx_bit_q <= rx_bit_q + 3'd1;
                        if (rx_bit_q == last_bit)
                            rx_st_q <= MPUL_MPB;
                    end
                end
                MPUL_MPB: begin
                    if (rx_smp)
                        rx_st_q <= MPUL_STOP;
                end
                MPUL_STOP: begin
                    if (rx_smp)
                        rx_st_q <= MPUL_IDLE;
                end
                default: rx_st_q <= MPUL_IDLE;
            endcase
        end
    end

    // Receive shift register and captured multiprocessor bit
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_shift_reg <= 8'h00;
            rx_mpb_in_q  <= 1'b0;
        end else if (rx_smp && rx_st_q == MPUL_DATA) begin
            rx_shift_reg <= {rxd_s2_q, rx_shift_reg[7:1]};
        end else if (rx_smp && rx_st_q == MPUL_MPB) begin
            rx_mpb_in_q <= rxd_s2_q;
        end
    end

    // Receive flags and buffer; hardware set wins over clears
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rx_holding_buffer   <= 8'h00;
            rx_buffer_full_flag <= 1'b0;
            overrun_flag        <= 1'b0;
            framing_flag        <= 1'b0;
            rx_mpb_q            <= 1'b0;
        end else begin
            if (rx_load) begin
                rx_holding_buffer <= rx_char;
                rx_mpb_q          <= rx_mpb_in_q;
            end
            // Framing error loads data but leaves the full flag clear
            if (rx_load && rx_stop)
                rx_buffer_full_flag <= 1'b1;
            else if (clr_rx_buffer_full_flag)
                rx_buffer_full_flag <= 1'b0;
            if (rx_ovr)
                overrun_flag <= 1'b1;
            else if (clr_overrun_flag)
                overrun_flag <= 1'b0;
            if (rx_acc && !rx_stop)
                framing_flag <= 1'b1;
            else if (clr_fer)
                framing_flag <= 1'b0;
        end
    end

    // Control register; a software write beats the auto-clear of ID-wait
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            serial_control_reg <= CTRL_RST;
            baud_q             <= BAUD_RST;
        end else begin
            if (wr_ctl)
                serial_control_reg <= ctl_new[CTRL_W-1:0];
            else if (rx_acc && rx_mpb_in_q)
                serial_control_reg[C_ADDR_WAIT_IRQ_ENABLE] <= 1'b0;
            if (wr_bd)
                baud_q <= lane_merge(baud_q, wb_dat_i[15:0], wb_sel_i[1:0]);
        end
    end

    // Interrupt requests are levels of flag and enable
    assign tx_empty_irq = tx_empty_irq_enable & tx_buffer_empty_flag;
    assign tx_end_irq   = tx_end_irq_enable & tx_end_flag;
    assign rx_full_irq  = rx_irq_enable & rx_buffer_full_flag;
    assign rx_error_irq = rx_irq_enable & rx_err;
    assign xfer_rx_data = rx_holding_buffer;

    // Read selection; rx pin level helps software spot a break
    wire [7:0] stat_rd = {rxd_s2_q, outgoing_addr_flag_bit, rx_mpb_q,
                          framing_flag, overrun_flag, rx_buffer_full_flag,
                          tx_end_flag, tx_buffer_empty_flag};
    wire [31:0] rd_mux =
        (wb_adr_i == ADDR_CTRL) ? {21'h0, serial_control_reg} :
        (wb_adr_i == ADDR_STAT) ? {24'h0, stat_rd} :
        (wb_adr_i == ADDR_TXD)  ? {24'h0, tx_holding_buffer} :
        (wb_adr_i == ADDR_RXD)  ? {24'h0, rx_holding_buffer} :
        (wb_adr_i == ADDR_BAUD) ? {16'h0, baud_q} : 32'h0;

    // One-wait-state ack; unmapped reads return zero
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0;
        end else begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q)
                rdat_q <= rd_mux;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_idle_new;
        tx_st_q == MPUL_IDLE && tx_new;
    endsequence
    sequence s_frame_go;
        tx_st_q == MPUL_START && tx_buffer_empty_flag;
    endsequence

    tx_load_a: assert property (s_idle_new |=> s_frame_go)
        else $error("idle load did not start frame");
    start_low_a: assert property (tx_st_q == MPUL_START && transmit_enable_bit
        |=> !txd_o)
        else $error("start bit not low");
    mpb_out_a: assert property (tx_st_q == MPUL_MPB && transmit_enable_bit
        |=> txd_o == tx_mpb_q)
        else $error("multiprocessor bit wrong");
    mark_high_a: assert property (tx_st_q == MPUL_STOP && transmit_enable_bit
        |=> txd_o)
        else $error("stop bit not high");
    tx_end_flag_set_a: assert property (tx_chk && tx_buffer_empty_flag
        |=> tx_end_flag && tx_end_irq == tx_end_irq_enable)
        else $error("transmit end not flagged");
    chain_load_a: assert property (tx_chk && tx_new
        |=> tx_pend_q && tx_buffer_empty_flag && !tx_end_flag)
        else $error("back to back frame not queued");
    xfer_clr_a: assert property (xfer_tx_wr && !tx_load && transmit_enable_bit
        |=> !tx_buffer_empty_flag)
        else $error("controller write left empty flag set");
    overrun_a: assert property (rx_ovr
        |=> overrun_flag && $stable(rx_holding_buffer))
        else $error("overrun mishandled");
    err_hold_a: assert property (rx_err && rx_st_q == MPUL_IDLE && !clr_overrun_flag
        && !clr_fer |=> rx_st_q == MPUL_IDLE [*2])
        else $error("receiver left idle with error");
    skip_data_a: assert property (rx_done && rx_skip
        |=> !$rose(rx_buffer_full_flag) && !$rose(framing_flag))
        else $error("data character not skipped");
endmodule

// file: mpul_peer.sv
// Peer station on the shared serial line: sends and captures frames.
// Assumes the divisor register holds 0, so one bit lasts 16 clocks.
`timescale 1ns/100ps
module mpul_peer (
    // Clock
    input  wire logic clk_sys,
    // Serial line
    input  wire logic line_in,
    output logic      rxd_out
);
    localparam int BIT = 16;
    // Line rests at mark between frames
    initial rxd_out = 1'b1;
    // One frame: start, 8 data LSB first, mp bit, stop; ID uses mp 1
    task automatic send(input logic [7:0] d, input logic mp);
        logic [10:0] f;
        f = {1'b1, mp, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_sys);
            rxd_out <= f[i];
            repeat (BIT - 1) @(posedge clk_sys);
        end
        repeat (8) @(posedge clk_sys);
    endtask
    // Break: line held low for n clocks, then back to mark
    task automatic brk(input int n);
        @(posedge clk_sys);
        rxd_out <= 1'b0;
        repeat (n) @(posedge clk_sys);
        rxd_out <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask
    // Samples each bit mid-cell, counted from the start edge
    task automatic grab(output logic [7:0] d, output logic mp, output logic stp);
        @(negedge line_in);
        repeat (8) @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT) @(posedge clk_sys);
            if (i < 8) d[i] = line_in;
            else if (i == 8) mp = line_in;
            else stp = line_in;
        end
    endtask
endmodule

// file: mpul_link_bench.sv
// Self-checking bench for the multiprocessor serial link.
// Assumes mpul_peer on the serial pins and a Wishbone master here.
`timescale 1ns/100ps
module mpul_link_bench;
    import mpul_pkg::*;
    logic        clk_sys, sys_rst, cyc, stb, we, ack, tx_wr, txd, oe_n, rxd;
    logic        ie_tx, ie_end, ie_full, ie_err, mp, stp;
    logic [7:0]  adr, tx_dat, rx_dat, d;
    logic [31:0] wdat, rdat, q;
    int          error_cnt, comparisons, cycles;
    // Released pin reads as mark, like a pulled-up line
    wire line = oe_n ? 1'b1 : txd;
    mpul_link mpul_link_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(4'h3), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(rdat), .wb_ack_o(ack), .xfer_tx_wr(tx_wr), .xfer_tx_data(tx_dat),
        .xfer_rx_rd(1'b0), .xfer_rx_data(rx_dat), .txd_o(txd), .txd_oe_n(oe_n),
        .rxd_i(rxd), .tx_empty_irq(ie_tx), .tx_end_irq(ie_end),
        .rx_full_irq(ie_full), .rx_error_irq(ie_err));
    mpul_peer mpul_peer_i (.clk_sys(clk_sys), .line_in(line), .rxd_out(rxd));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= v;
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic t_reset();
        wb(0, ADDR_CTRL, 0); chk("ctrl", 32'h0000_0040, q);
        wb(0, ADDR_STAT, 0); chk("stat", 32'h0000_0083, q);
        wb(0, 8'h14, 0); chk("unmapped", 32'h0, q);
        chk("txd idle", 1'b1, line);
        $display("reset test done");
    endtask
    // Controller write clears empty flag; parity enable set but ignored
    task automatic t_tx();
        wb(1, ADDR_BAUD, 0); wb(1, ADDR_CTRL, 32'h0000_0151);
        wb(1, ADDR_STAT, 32'h0000_005f);
        fork
            mpul_peer_i.grab(d, mp, stp);
            begin
                @(posedge clk_sys); tx_wr <= 1'b1; tx_dat <= 8'ha5;
                @(posedge clk_sys); tx_wr <= 1'b0;
            end
        join
        chk("tx data", 8'ha5, d);
        chk("tx mp", 1'b1, mp);
        chk("tx stop", 1'b1, stp);
        repeat (20) @(posedge clk_sys);
        chk("tx end irq", 1'b1, ie_end);
        wb(0, ADDR_STAT, 0); chk("stat tx", 32'h0000_00c3, q);
        $display("transmit test done");
    endtask
    task automatic t_rx_id();
        wb(1, ADDR_CTRL, 32'h0000_006b);
        mpul_peer_i.send(8'h11, 1'b0);
        chk("data skipped", 1'b0, ie_full);
        mpul_peer_i.send(8'h5a, 1'b1);
        chk("id irq", 1'b1, ie_full);
        chk("rx data", 8'h5a, rx_dat);
        wb(0, ADDR_CTRL, 0); chk("id wait off", 32'h0000_004b, q);
        $display("id receive test done");
    endtask
    // Second character while full: overrun, buffer kept
    task automatic t_overrun();
        mpul_peer_i.send(8'h33, 1'b0);
        chk("err irq", 1'b1, ie_err);
        wb(0, ADDR_RXD, 0); chk("rx kept", 32'h0000_005a, q);
        $display("overrun test done");
    endtask
    // Errors cleared, then a break: framing error, pin read low, receiver held
    task automatic t_break();
        wb(1, ADDR_STAT, 32'h0000_0013);
        fork
            mpul_peer_i.brk(240);
            begin
                repeat (200) @(posedge clk_sys);
                wb(0, ADDR_STAT, 0);
                chk("framing", 1'b1, q[S_FER]);
                chk("break pin", 1'b0, q[S_RXPIN]);
                chk("full clear", 1'b0, q[S_RX_BUFFER_FULL_FLAG]);
            end
        join
        chk("brk err irq", 1'b1, ie_err);
        chk("brk data", 8'h00, rx_dat);
        wb(1, ADDR_STAT, 32'h0000_000f);
        wb(0, ADDR_STAT, 0); chk("fer cleared", 1'b0, q[S_FER]);
        $display("break receive test done");
    endtask
    // Foreign ID: software re-arms ID-wait, clears full, data then skipped
    task automatic t_id_miss();
        wb(1, ADDR_CTRL, 32'h0000_006b);
        mpul_peer_i.send(8'h22, 1'b1);
        wb(0, ADDR_RXD, 0); chk("other id", 32'h0000_0022, q);
        if (q[7:0] != 8'h5a) wb(1, ADDR_CTRL, 32'h0000_006b);
        wb(1, ADDR_STAT, 32'h0000_001b);
        mpul_peer_i.send(8'h44, 1'b0);
        chk("not for us", 1'b0, ie_full);
        wb(0, ADDR_RXD, 0); chk("rx unchanged", 32'h0000_0022, q);
        $display("id mismatch test done");
    endtask
    // Software sends ID then data back to back, two stop bits
    task automatic t_chain();
        logic [7:0] d2;
        logic       mp2, s2;
        wb(1, ADDR_CTRL, 32'h0000_00c5);
        wb(0, ADDR_STAT, 0); chk("tx_buffer_empty_flag before", 1'b1, q[S_TX_BUFFER_EMPTY_FLAG]);
        chk("tx empty irq", 1'b1, ie_tx);
        fork
            begin
                mpul_peer_i.grab(d, mp, stp);
                mpul_peer_i.grab(d2, mp2, s2);
            end
            begin
                wb(1, ADDR_TXD, 32'h0000_0011);
                wb(1, ADDR_STAT, 32'h0000_005e);
                wb(0, ADDR_STAT, 0); chk("tx_buffer_empty_flag reloaded", 1'b1, q[S_TX_BUFFER_EMPTY_FLAG]);
                wb(1, ADDR_TXD, 32'h0000_0096);
                wb(1, ADDR_STAT, 32'h0000_001e);
            end
        join
        chk("chain id", 8'h11, d);
        chk("chain id mp", 1'b1, mp);
        chk("chain data", 8'h96, d2);
        chk("chain data mp", 1'b0, mp2);
        chk("chain stop", 1'b1, s2);
        repeat (40) @(posedge clk_sys);
        wb(0, ADDR_STAT, 0); chk("chain end", 1'b1, q[S_TX_END_FLAG]);
        $display("chained transmit test done");
    endtask
    // Break out: port bits first, then transmit enable dropped
    task automatic t_txbreak();
        wb(1, ADDR_CTRL, 32'h0000_0241);
        wb(1, ADDR_CTRL, 32'h0000_0240);
        repeat (2) @(posedge clk_sys);
        chk("break out", 1'b0, line);
        wb(0, ADDR_STAT, 0); chk("te off flags", 2'b11, q[1:0]);
        $display("break transmit test done");
    endtask
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Ceiling well above all frames, the break and bus traffic
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        {cyc, stb, we, tx_wr, adr, tx_dat, wdat} = '0;
        sys_rst = 1'b1; error_cnt = 0; comparisons = 0; cycles = 0;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset(); t_tx(); t_rx_id(); t_overrun();
        t_break(); t_id_miss(); t_chain(); t_txbreak();
        wrap_up();
    end
endmodule
